// [verilog/itc_pkg.sv]
package itc_pkg;

  localparam int NODE_COUNT = 8;
  localparam int TRAP_COUNT = 5;

  // register word addresses
  localparam logic [4:0] ADDR_SEGMENT = 5'h00;
  localparam logic [4:0] ADDR_CONFIG = 5'h01;
  localparam logic [4:0] ADDR_TRAP_FLAGS = 5'h02;
  localparam logic [4:0] ADDR_EVENT_STATUS = 5'h03;
  localparam logic [4:0] ADDR_EVENT_MASK = 5'h04;
  localparam logic [4:0] ADDR_NODE_BASE = 5'h08;

  // node control word layout
  localparam int NODE_PRIO_LSB = 0;
  localparam int NODE_ENABLE_BIT = 6;
  localparam int NODE_REQUEST_BIT = 7;
  localparam int NODE_XFER_BIT = 8;

  // configuration and reset values
  localparam int CONFIG_SPACING_LSB = 0;
  localparam logic [1:0] SPACING_RESET = 2'h0;
  localparam int SPACING_BASE_SHIFT = 2;
  localparam logic [7:0] SEGMENT_RESET = 8'h00;

  // event status bits
  localparam int EV_TRAP = 0;
  localparam int EV_IRQ = 1;
  localparam int EV_XFER = 2;
  localparam int EV_WIDTH = 3;

  // hardware traps, index 0 is the most urgent
  localparam logic [6:0] TRAP_NUM [TRAP_COUNT] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h0A};

  // fixed node trap numbers
  localparam logic [6:0] NODE_NUM [NODE_COUNT] = '{7'h20, 7'h21, 7'h28, 7'h2A, 7'h2B, 7'h43, 7'h48, 7'h4C};
  localparam int UNASSIGNED_NODE = 2;
  localparam int SECOND_ASC_NODE = 6;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_OFFER = 2'b10} state_t;

endpackage

// [verilog/vector_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module vector_calc
(
  // programmed placement
  input wire logic [7:0] segment,
  input wire logic [1:0] spacing,
  // selected trap
  input wire logic [6:0] trap_number,
  output logic [23:0] address
);

  logic [15:0] offset;

  always_comb
  begin
    offset = {9'h000, trap_number} << (itc_pkg::SPACING_BASE_SHIFT + int'(spacing));
    address = {segment, offset};
  end

endmodule
`default_nettype wire

// [verilog/node_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module node_ctrl
#(
  parameter bit ASSIGNED = 1'b1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // request sources
  input wire logic hw_event,
  input wire logic svc_clear,
  // software access
  input wire logic wr_sel,
  input wire logic [15:0] wdata,
  output logic [15:0] word
);

  logic [3:0] prio;
  logic enable;
  logic request;
  logic xfer;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prio <= 4'h0;
      enable <= 1'b0;
      xfer <= 1'b0;
    end
    else if (wr_sel)
    begin
      prio <= wdata[itc_pkg::NODE_PRIO_LSB +: 4];
      enable <= wdata[itc_pkg::NODE_ENABLE_BIT];
      xfer <= wdata[itc_pkg::NODE_XFER_BIT];
    end
  end

  // a peripheral event wins over the service clear
  always_ff @(posedge clock)
  begin
    if (rst)
      request <= 1'b0;
    else if (ASSIGNED && hw_event)
      request <= 1'b1;
    else if (wr_sel)
      request <= wdata[itc_pkg::NODE_REQUEST_BIT];
    else if (svc_clear)
      request <= 1'b0;
  end

  always_comb
  begin
    word = 16'h0000;
    word[itc_pkg::NODE_PRIO_LSB +: 4] = prio;
    word[itc_pkg::NODE_ENABLE_BIT] = enable;
    word[itc_pkg::NODE_REQUEST_BIT] = request;
    word[itc_pkg::NODE_XFER_BIT] = xfer;
  end

  property p_soft_request;
    @(posedge clock) disable iff (rst) wr_sel && wdata[itc_pkg::NODE_REQUEST_BIT] |=> request;
  endproperty
  a_soft_request: assert property (p_soft_request) else $error("software request not taken");
  property p_absent_port;
    @(posedge clock) disable iff (rst) !ASSIGNED && hw_event && !request && !wr_sel |=> !request;
  endproperty
  a_absent_port: assert property (p_absent_port) else $error("absent port node raised");

endmodule
`default_nettype wire

// [verilog/trap_vector_unit.sv]
// Overview of operation
// - every vector address lies in the segment held by the vector segment register
// - vector spacing field selects distance between vectors, four bytes by default
// - each node has a fixed trap number; default offset is number times four
// - the second serial port node acts as unassigned when that port is absent
// - hardware traps are offered at once and cannot be masked
// - each hardware trap sets its own bit in the trap flag register
// - a trap preempts anything except a higher or equal priority trap service
// - during trap service no interrupt or transfer request is offered
// - software may set a node request bit and it is serviced normally
// - each node has request flag, enable flag and sixteen-level priority
// - only a strictly higher priority than the current level is offered
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module trap_vector_unit
#(
  parameter bit HAS_SECOND_ASC = 1'b1
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // request sources
  input wire logic [itc_pkg::TRAP_COUNT-1:0] TRAP_EVENT,
  input wire logic [itc_pkg::NODE_COUNT-1:0] NODE_EVENT,
  // core side
  input wire logic [3:0] CPU_LEVEL,
  input wire logic SERVICE_ACK,
  input wire logic TRAP_RETURN,
  output logic VECTOR_REQ,
  output logic VECTOR_IS_TRAP,
  output logic [6:0] VECTOR_TRAP,
  output logic [23:0] VECTOR_ADDR,
  output logic TRANSFER_REQ,
  output logic [2:0] TRANSFER_NODE,
  // interrupt
  output logic IRQ
);

  localparam int NC = itc_pkg::NODE_COUNT;
  localparam int TC = itc_pkg::TRAP_COUNT;

  itc_pkg::state_t state;
  logic [7:0] segment;
  logic [1:0] spacing;
  logic [TC-1:0] trap_flags, trap_pending, in_svc, next_in_svc;
  logic [itc_pkg::EV_WIDTH-1:0] event_status, event_mask, event_set;
  logic [15:0] node_word [NC];
  logic [NC-1:0] node_req, node_en, node_xfer, node_wr, node_clear;
  logic [3:0] node_prio [NC];
  logic [2:0] offer_idx, trap_idx, node_idx, node_sel;
  logic [3:0] offer_prio, node_best;
  logic trap_found, blocked, node_found, ack_trap, ack_node, dropped, node_hit;
  logic [6:0] next_number;
  logic [23:0] next_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // request nodes

  assign node_hit = ADDR >= itc_pkg::ADDR_NODE_BASE && ADDR < itc_pkg::ADDR_NODE_BASE + 5'(NC);
  assign node_sel = 3'(ADDR - itc_pkg::ADDR_NODE_BASE);

  genvar k;
  generate
    for (k = 0; k < NC; k++)
    begin : g_node
      localparam bit ASSIGNED = (k != itc_pkg::UNASSIGNED_NODE) &&
                                (k != itc_pkg::SECOND_ASC_NODE || HAS_SECOND_ASC);
      assign node_wr[k] = WR && node_hit && node_sel == 3'(k);
      assign node_clear[k] = ack_node && offer_idx == 3'(k);
      node_ctrl #(.ASSIGNED(ASSIGNED)) u_node
      (
        .clock(CLOCK),
        .rst(RST),
        .hw_event(NODE_EVENT[k]),
        .svc_clear(node_clear[k]),
        .wr_sel(node_wr[k]),
        .wdata(WDATA),
        .word(node_word[k])
      );
      assign node_req[k] = node_word[k][itc_pkg::NODE_REQUEST_BIT];
      assign node_en[k] = node_word[k][itc_pkg::NODE_ENABLE_BIT];
      assign node_xfer[k] = node_word[k][itc_pkg::NODE_XFER_BIT];
      assign node_prio[k] = node_word[k][itc_pkg::NODE_PRIO_LSB +: 4];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // selection

  always_comb
  begin
    trap_found = 1'b0;
    trap_idx = 3'h0;
    blocked = 1'b0;
    for (int i = 0; i < TC; i++)
    begin
      blocked = blocked | in_svc[i];
      if (!trap_found && trap_pending[i] && !blocked)
      begin
        trap_found = 1'b1;
        trap_idx = 3'(i);
      end
    end
  end

  // strict compare keeps the lower node on a tie
  always_comb
  begin
    node_found = 1'b0;
    node_idx = 3'h0;
    node_best = CPU_LEVEL;
    for (int i = 0; i < NC; i++)
    begin
      if (node_req[i] && node_en[i] && node_prio[i] > node_best)
      begin
        node_found = 1'b1;
        node_idx = 3'(i);
        node_best = node_prio[i];
      end
    end
  end

  assign next_number = trap_found ? itc_pkg::TRAP_NUM[trap_idx] : itc_pkg::NODE_NUM[node_idx];

  vector_calc u_vector
  (
    .segment(segment),
    .spacing(spacing),
    .trap_number(next_number),
    .address(next_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // offer to the core

  assign ack_trap = SERVICE_ACK && state == itc_pkg::ST_OFFER && VECTOR_IS_TRAP;
  assign ack_node = SERVICE_ACK && state == itc_pkg::ST_OFFER && !VECTOR_IS_TRAP;

  // the offer is re-chosen every cycle so a new trap displaces a waiting request
  always_ff @(posedge CLOCK)
  begin
    if (RST || SERVICE_ACK)
    begin
      state <= itc_pkg::ST_IDLE;
      VECTOR_REQ <= 1'b0;
      VECTOR_IS_TRAP <= 1'b0;
      TRANSFER_REQ <= 1'b0;
    end
    else if (trap_found)
    begin
      state <= itc_pkg::ST_OFFER;
      VECTOR_REQ <= 1'b1;
      VECTOR_IS_TRAP <= 1'b1;
      TRANSFER_REQ <= 1'b0;
    end
    else if (node_found && in_svc == '0)
    begin
      state <= itc_pkg::ST_OFFER;
      VECTOR_REQ <= !node_xfer[node_idx];
      VECTOR_IS_TRAP <= 1'b0;
      TRANSFER_REQ <= node_xfer[node_idx];
    end
    else
    begin
      state <= itc_pkg::ST_IDLE;
      VECTOR_REQ <= 1'b0;
      VECTOR_IS_TRAP <= 1'b0;
      TRANSFER_REQ <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      offer_idx <= 3'h0;
      offer_prio <= 4'h0;
      VECTOR_TRAP <= 7'h00;
      VECTOR_ADDR <= 24'h000000;
      TRANSFER_NODE <= 3'h0;
    end
    else
    begin
      offer_idx <= trap_found ? trap_idx : node_idx;
      offer_prio <= node_best;
      VECTOR_TRAP <= next_number;
      VECTOR_ADDR <= next_addr;
      TRANSFER_NODE <= node_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trap bookkeeping

  // an event in the clearing cycle keeps its flag
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      trap_flags <= '0;
    else if (WR && ADDR == itc_pkg::ADDR_TRAP_FLAGS)
      trap_flags <= (trap_flags & ~WDATA[TC-1:0]) | TRAP_EVENT;
    else
      trap_flags <= trap_flags | TRAP_EVENT;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      trap_pending <= '0;
    else
      trap_pending <= (trap_pending & ~(TC'(ack_trap) << offer_idx)) | TRAP_EVENT;
  end

  // return ends the most urgent running trap, nesting unwinds in order
  always_comb
  begin
    next_in_svc = in_svc;
    dropped = 1'b0;
    for (int i = 0; i < TC; i++)
    begin
      if (TRAP_RETURN && !dropped && in_svc[i])
      begin
        next_in_svc[i] = 1'b0;
        dropped = 1'b1;
      end
    end
    if (ack_trap)
      next_in_svc[offer_idx] = 1'b1;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      in_svc <= '0;
    else
      in_svc <= next_in_svc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and interrupt

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      segment <= itc_pkg::SEGMENT_RESET;
      spacing <= itc_pkg::SPACING_RESET;
      event_mask <= '0;
    end
    else if (WR)
    begin
      if (ADDR == itc_pkg::ADDR_SEGMENT)
        segment <= WDATA[7:0];
      if (ADDR == itc_pkg::ADDR_CONFIG)
        spacing <= WDATA[itc_pkg::CONFIG_SPACING_LSB +: 2];
      if (ADDR == itc_pkg::ADDR_EVENT_MASK)
        event_mask <= WDATA[itc_pkg::EV_WIDTH-1:0];
    end
  end

  always_comb
  begin
    event_set = '0;
    event_set[itc_pkg::EV_TRAP] = ack_trap;
    event_set[itc_pkg::EV_IRQ] = ack_node && VECTOR_REQ;
    event_set[itc_pkg::EV_XFER] = ack_node && TRANSFER_REQ;
  end

  // read clears, a new event in that cycle survives
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      event_status <= '0;
    else if (RD && ADDR == itc_pkg::ADDR_EVENT_STATUS)
      event_status <= event_set;
    else
      event_status <= event_status | event_set;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(event_status & event_mask);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST || !RD)
      RDATA <= 16'h0000;
    else if (node_hit)
      RDATA <= node_word[node_sel];
    else
    begin
      unique case (ADDR)
        itc_pkg::ADDR_SEGMENT: RDATA <= {8'h00, segment};
        itc_pkg::ADDR_CONFIG: RDATA <= {14'h0000, spacing};
        itc_pkg::ADDR_TRAP_FLAGS: RDATA <= 16'(trap_flags);
        itc_pkg::ADDR_EVENT_STATUS: RDATA <= 16'(event_status);
        itc_pkg::ADDR_EVENT_MASK: RDATA <= 16'(event_mask);
        default: RDATA <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_trap_arrives;
    TRAP_EVENT != '0 && in_svc == '0 && !SERVICE_ACK ##1 !SERVICE_ACK;
  endsequence
  sequence s_vector_offered;
    VECTOR_REQ && $past(!SERVICE_ACK);
  endsequence
  property p_trap_at_once;
    @(posedge CLOCK) disable iff (RST) s_trap_arrives |=> VECTOR_REQ && VECTOR_IS_TRAP;
  endproperty
  a_trap_at_once: assert property (p_trap_at_once) else $error("trap not offered at once");
  property p_trap_flag;
    @(posedge CLOCK) disable iff (RST) TRAP_EVENT != '0 |=> (trap_flags & $past(TRAP_EVENT)) == $past(TRAP_EVENT);
  endproperty
  a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");
  property p_segment;
    @(posedge CLOCK) disable iff (RST) s_vector_offered |-> VECTOR_ADDR[23:16] == $past(segment);
  endproperty
  a_segment: assert property (p_segment) else $error("vector outside segment");
  property p_spacing;
    @(posedge CLOCK) disable iff (RST)
      s_vector_offered |-> VECTOR_ADDR[15:0] == ({9'h000, VECTOR_TRAP} << (2 + int'($past(spacing))));
  endproperty
  a_spacing: assert property (p_spacing) else $error("vector spacing wrong");
  property p_default_offset;
    @(posedge CLOCK) disable iff (RST)
      s_vector_offered and $past(spacing) == 2'h0 |-> VECTOR_ADDR[15:0] == {7'h00, VECTOR_TRAP, 2'h0};
  endproperty
  a_default_offset: assert property (p_default_offset) else $error("default offset not times four");
  property p_trap_blocks_nodes;
    @(posedge CLOCK) disable iff (RST) in_svc != '0 |=> !TRANSFER_REQ && (!VECTOR_REQ || VECTOR_IS_TRAP);
  endproperty
  a_trap_blocks_nodes: assert property (p_trap_blocks_nodes) else $error("request during trap service");
  property p_lower_trap_waits;
    @(posedge CLOCK) disable iff (RST) in_svc[0] && trap_pending[TC-1] |=> trap_pending[TC-1];
  endproperty
  a_lower_trap_waits: assert property (p_lower_trap_waits) else $error("lower trap lost");
  property p_strict_priority;
    @(posedge CLOCK) disable iff (RST)
      (VECTOR_REQ && !VECTOR_IS_TRAP) || TRANSFER_REQ |-> offer_prio > $past(CPU_LEVEL);
  endproperty
  a_strict_priority: assert property (p_strict_priority) else $error("priority not higher");
  property p_nested_trap;
    @(posedge CLOCK) disable iff (RST) VECTOR_REQ && VECTOR_IS_TRAP |-> ($past(in_svc) & ((5'h01 << offer_idx) | ((5'h01 << offer_idx) - 5'h01))) == '0;
  endproperty
  a_nested_trap: assert property (p_nested_trap) else $error("trap offered under higher service");

endmodule
`default_nettype wire

// [bench/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // offer from the unit
  input wire logic vector_req,
  input wire logic transfer_req,
  input wire logic [6:0] vector_trap,
  input wire logic [23:0] vector_addr,
  input wire logic [2:0] transfer_node,
  // answer speed
  input wire logic [3:0] delay,
  // acceptance
  output logic service_ack,
  output logic [23:0] taken,
  output logic [6:0] taken_trap,
  output int accepted
);
  logic [3:0] wait_count;

  ////////////////////////////////////////////////////////////////
  // ack only while an offer shows, one cycle long
  always_ff @(posedge clock)
  begin
    if (rst || service_ack)
    begin
      service_ack <= 1'b0;
      wait_count <= 4'h0;
    end
    else if ((vector_req || transfer_req) && wait_count == delay)
      service_ack <= 1'b1;
    else if (vector_req || transfer_req)
      wait_count <= wait_count + 4'h1;
  end

  ////////////////////////////////////////////////////////////////
  // transfers marked by 7F, as no trap number reaches it here
  always_ff @(posedge clock)
  begin
    if (rst)
      accepted <= 0;
    else if (service_ack)
    begin
      accepted <= accepted + 1;
      taken <= transfer_req ? {21'h000000, transfer_node} : vector_addr;
      taken_trap <= transfer_req ? 7'h7F : vector_trap;
    end
  end
endmodule
`default_nettype wire

// [bench/trap_vector_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module trap_vector_unit_bench;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA;
  logic [4:0] TRAP_EVENT = 5'h00;
  logic [7:0] NODE_EVENT = 8'h00;
  logic [3:0] CPU_LEVEL = 4'h0;
  logic SERVICE_ACK;
  logic TRAP_RETURN = 1'b0;
  logic VECTOR_REQ;
  logic VECTOR_IS_TRAP;
  logic [6:0] VECTOR_TRAP;
  logic [23:0] VECTOR_ADDR;
  logic TRANSFER_REQ;
  logic [2:0] TRANSFER_NODE;
  logic IRQ;
  logic [3:0] ack_delay = 4'h0;
  logic [23:0] taken;
  logic [6:0] taken_trap;
  int accepted;
  int fail_count = 0;
  int n_compared = 0;

  always #2.5 CLOCK = ~CLOCK;

  // variant without the second serial port
  trap_vector_unit #(.HAS_SECOND_ASC(1'b0)) u_trap_vector_unit (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TRAP_EVENT(TRAP_EVENT), .NODE_EVENT(NODE_EVENT),
    .CPU_LEVEL(CPU_LEVEL), .SERVICE_ACK(SERVICE_ACK), .TRAP_RETURN(TRAP_RETURN), .VECTOR_REQ(VECTOR_REQ),
    .VECTOR_IS_TRAP(VECTOR_IS_TRAP), .VECTOR_TRAP(VECTOR_TRAP), .VECTOR_ADDR(VECTOR_ADDR),
    .TRANSFER_REQ(TRANSFER_REQ), .TRANSFER_NODE(TRANSFER_NODE), .IRQ(IRQ));

  core_model u_core_model (.clock(CLOCK), .rst(RST), .vector_req(VECTOR_REQ), .transfer_req(TRANSFER_REQ),
    .vector_trap(VECTOR_TRAP), .vector_addr(VECTOR_ADDR), .transfer_node(TRANSFER_NODE), .delay(ack_delay),
    .service_ack(SERVICE_ACK), .taken(taken), .taken_trap(taken_trap), .accepted(accepted));

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [4:0] a, input logic [15:0] e);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    chk(what, {8'h00, e}, {8'h00, RDATA});
  endtask

  task automatic ev(input logic [4:0] t, input logic [7:0] n);
    @(posedge CLOCK);
    TRAP_EVENT <= t;
    NODE_EVENT <= n;
    @(posedge CLOCK);
    TRAP_EVENT <= 5'h00;
    NODE_EVENT <= 8'h00;
  endtask

  task automatic ret();
    @(posedge CLOCK);
    TRAP_RETURN <= 1'b1;
    @(posedge CLOCK);
    TRAP_RETURN <= 1'b0;
  endtask

  // waits for the core to accept one offer
  task automatic take(input logic [6:0] t, input logic [23:0] a);
    int start;
    int n;
    start = accepted;
    n = 0;
    while (accepted == start && n < 40)
    begin
      @(negedge CLOCK);
      n++;
    end
    chk("accepted", start[23:0] + 24'h000001, accepted[23:0]);
    chk("vector trap", {17'h00000, t}, {17'h00000, taken_trap});
    chk("vector address", a, taken);
  endtask

  task automatic quiet(input int cycles);
    int start;
    start = accepted;
    repeat (cycles) @(negedge CLOCK);
    chk("offer count", start[23:0], accepted[23:0]);
  endtask

  function automatic logic [23:0] vaddr(input logic [7:0] s, input logic [6:0] t, input int sp);
    return {s, {9'h000, t} << (2 + sp)};
  endfunction

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    rd("segment", itc_pkg::ADDR_SEGMENT, {8'h00, itc_pkg::SEGMENT_RESET});
    rd("config", itc_pkg::ADDR_CONFIG, {14'h0000, itc_pkg::SPACING_RESET});
    rd("trap flags", itc_pkg::ADDR_TRAP_FLAGS, 16'h0000);
    wr(5'h1F, 16'hFFFF);
    rd("unmapped", 5'h1F, 16'h0000);
    $display("test reset done");
    wr(itc_pkg::ADDR_SEGMENT, 16'h0012);
    wr(itc_pkg::ADDR_EVENT_MASK, 16'h0007);
    for (int i = 0; i < itc_pkg::TRAP_COUNT; i++)
    begin
      ev(5'h01 << i, 8'h00);
      take(itc_pkg::TRAP_NUM[i], vaddr(8'h12, itc_pkg::TRAP_NUM[i], 0));
      ret();
    end
    rd("trap flags", itc_pkg::ADDR_TRAP_FLAGS, 16'h001F);
    wr(itc_pkg::ADDR_TRAP_FLAGS, 16'h001F);
    rd("trap flags", itc_pkg::ADDR_TRAP_FLAGS, 16'h0000);
    chk("irq", 24'h000001, {23'h000000, IRQ});
    rd("status", itc_pkg::ADDR_EVENT_STATUS, 16'h0001);
    repeat (2) @(negedge CLOCK);
    chk("irq", 24'h000000, {23'h000000, IRQ});
    $display("test traps done");
    wr(itc_pkg::ADDR_NODE_BASE, 16'h0045);
    for (int sp = 0; sp < 4; sp++)
    begin
      ack_delay <= sp[3:0];
      wr(itc_pkg::ADDR_CONFIG, sp[15:0]);
      ev(5'h00, 8'h01);
      take(7'h20, vaddr(8'h12, 7'h20, sp));
    end
    ack_delay <= 4'h0;
    wr(itc_pkg::ADDR_CONFIG, 16'h0000);
    CPU_LEVEL <= 4'h5;
    ev(5'h00, 8'h01);
    quiet(10);
    @(posedge CLOCK);
    CPU_LEVEL <= 4'h4;
    take(7'h20, 24'h120080);
    @(posedge CLOCK);
    CPU_LEVEL <= 4'h0;
    wr(itc_pkg::ADDR_NODE_BASE, 16'h004E);
    wr(itc_pkg::ADDR_NODE_BASE + 5'h01, 16'h004F);
    ev(5'h00, 8'h03);
    take(7'h21, 24'h120084);
    take(7'h20, 24'h120080);
    rd("node word", itc_pkg::ADDR_NODE_BASE + 5'h01, 16'h004F);
    $display("test nodes done");
    wr(itc_pkg::ADDR_EVENT_MASK, 16'h0000);
    ev(5'h01, 8'h00);
    take(7'h02, 24'h120008);
    ev(5'h10, 8'h01);
    quiet(10);
    chk("irq", 24'h000000, {23'h000000, IRQ});
    rd("trap flags", itc_pkg::ADDR_TRAP_FLAGS, 16'h0011);
    ret();
    take(7'h0A, 24'h120028);
    ev(5'h02, 8'h00);
    take(7'h04, 24'h120010);
    ret();
    quiet(5);
    ret();
    take(7'h20, 24'h120080);
    $display("test nesting done");
    wr(itc_pkg::ADDR_NODE_BASE + 5'h06, 16'h0047);
    ev(5'h00, 8'h40);
    quiet(10);
    wr(itc_pkg::ADDR_NODE_BASE + 5'h06, 16'h00C7);
    take(7'h48, 24'h120120);
    wr(itc_pkg::ADDR_NODE_BASE + 5'h02, 16'h00C3);
    take(7'h28, 24'h1200A0);
    wr(itc_pkg::ADDR_NODE_BASE + 5'h03, 16'h0146);
    ev(5'h00, 8'h08);
    take(7'h7F, 24'h000003);
    rd("status", itc_pkg::ADDR_EVENT_STATUS, 16'h0007);
    rd("status", itc_pkg::ADDR_EVENT_STATUS, 16'h0000);
    $display("test software done");
    conclude();
  end

  // whole sequence needs well under a thousand cycles
  initial
  begin
    #(5 * 5000);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
